//--- dv/tae_host_model.sv
// two-wire bus host model that programs and reads the sensor registers
`timescale 1ns/10ps
module tae_host_model #(
	parameter logic [6:0] DEV = 7'h1d
) (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// scl pace far above 10 kHz
	task automatic qtr(input int n);
		repeat (n * 6) @(negedge clk_i);
	endtask

	task automatic hold(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic bus_start();
		sda_o = 1'b1;
		qtr(1);
		scl_o = 1'b1;
		qtr(1);
		sda_o = 1'b0;
		qtr(1);
		scl_o = 1'b0;
		qtr(1);
	endtask

	task automatic bus_stop();
		sda_o = 1'b0;
		qtr(1);
		scl_o = 1'b1;
		qtr(1);
		sda_o = 1'b1;
		qtr(2);
	endtask

	// eight data bits then the acknowledge bit, msb first
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			sda_o = d[i];
			qtr(1);
			scl_o = 1'b1;
			qtr(1);
			q[i] = sda_i;
			qtr(1);
			scl_o = 1'b0;
			qtr(1);
		end
	endtask

	task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] d, output logic ok);
		logic [8:0] q0;
		logic [8:0] q1;
		logic [8:0] q2;
		logic [8:0] q3;
		bus_start();
		xfer({DEV, 1'b0, 1'b1}, q0);
		xfer({ptr, 1'b1}, q1);
		xfer({d[15:8], 1'b1}, q2);
		xfer({d[7:0], 1'b1}, q3);
		bus_stop();
		ok = ~(q0[0] | q1[0] | q2[0] | q3[0]);
	endtask

	task automatic rd_reg(input logic [7:0] ptr, output logic [15:0] d);
		logic [8:0] q0;
		logic [8:0] q1;
		bus_start();
		xfer({DEV, 1'b0, 1'b1}, q0);
		xfer({ptr, 1'b1}, q0);
		bus_start();
		xfer({DEV, 1'b1, 1'b1}, q0);
		xfer(9'h1fe, q0);
		xfer(9'h1ff, q1);
		bus_stop();
		d = {q0[8:1], q1[8:1]};
	endtask
endmodule

//--- dv/tb_thermal_alarm_event_logic.sv
// self-checking bench for the thermal alarm block
`timescale 1ns/10ps
module tb_thermal_alarm_event_logic import tae_pkg::*;;
	localparam int CONV = 200;
	localparam int TOUT = 100;
	localparam logic [5:0][7:0] DPTR = {REG_SMB, REG_CRIT, REG_LOWER, REG_UPPER, REG_CFG, REG_CAP};
	// zero limits leave every nonzero temperature outside the window, so status reads set
	localparam logic [5:0][15:0] DVAL = {SMB_RST, LIM_RST, LIM_RST, LIM_RST,
		CFG_RST | (16'h0001 << CFG_STAT), CAP_VAL};
	logic clk_i;
	logic conv_clk;
	logic rst_n;
	logic scl;
	logic host_sda;
	logic sda_w;
	logic conv_start;
	logic pend;
	logic ok;
	logic [8:0] q;
	logic [12:0] cur_temp;
	logic [15:0] rd;
	tae_conv_t conv;
	tae_od_t sda_o;
	tae_od_t event_o;
	int bad_count;
	int n_compared;

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		conv_clk = 1'b0;
		#3;
		forever #7.5 conv_clk = ~conv_clk;
	end
	// scl comes from the host alone
	assign sda_w = host_sda & (sda_o.oe_n | sda_o.o);

	tae_thermal_alarm #(
		.CONV_CYCLES(CONV),
		.TOUT_CYCLES(TOUT)
	) i_tae_thermal_alarm (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.conv_clk_i(conv_clk),
		.scl_i(scl),
		.sda_i(sda_w),
		.addr_sel_i(3'h5),
		.conv_i(conv),
		.conv_start_o(conv_start),
		.sda_o(sda_o),
		.event_o(event_o)
	);

	tae_host_model #(
		.DEV(7'h1d)
	) i_tae_host_model (
		.clk_i(clk_i),
		.sda_i(sda_w),
		.scl_o(scl),
		.sda_o(host_sda)
	);

	// converter answers one cycle after a request, data scrambled otherwise
	initial begin
		conv = '0;
		pend = 1'b0;
	end
	always @(negedge conv_clk) begin
		if (pend) begin
			conv <= {1'b1, cur_temp};
			pend <= 1'b0;
		end else begin
			conv <= {1'b0, ~cur_temp};
			pend <= conv_start;
		end
	end

	task automatic chk_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
		i_tae_host_model.wr_reg(ptr, d, ok);
		chk_bit("write ack", 1'b1, ok);
	endtask

	task automatic rdc(input string name, input logic [7:0] ptr, input logic [15:0] exp);
		i_tae_host_model.rd_reg(ptr, rd);
		chk_reg(name, exp, rd);
	endtask

	task automatic evt(input logic exp);
		chk_bit("event release", exp, event_o.oe_n);
	endtask

	task automatic set_temp(input logic [12:0] t);
		cur_temp = t;
		repeat (3 * CONV + 60) @(negedge clk_i);
	endtask

	task automatic test_end(input string name);
		$display("test %s ended, %0d mismatches so far", name, bad_count);
	endtask

	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clk_i);
		bad_count++;
		results();
	end

	initial begin
		rst_n = 1'b0;
		cur_temp = 13'h0400;
		bad_count = 0;
		n_compared = 0;
		repeat (3) @(negedge clk_i);
		rst_n = 1'b1;
		repeat (3) @(negedge clk_i);
		evt(1'b1);
		for (int i = 0; i < 6; i++) begin
			rdc("default", DPTR[i], DVAL[i]);
		end
		test_end("defaults");
		wr(REG_LOWER, 16'h0100);
		wr(REG_UPPER, 16'h0553);
		wr(REG_CRIT, 16'h05f0);
		wr(REG_CAP, 16'hffff);
		rdc("upper", REG_UPPER, 16'h0553 & LIM_MASK);
		rdc("capability", REG_CAP, CAP_VAL);
		test_end("limits");
		set_temp(13'h0400);
		wr(REG_CFG, 16'h0008);
		set_temp(13'h0400);
		evt(1'b1);
		rdc("temp", REG_TEMP, 16'h0400);
		set_temp(13'h0580);
		evt(1'b0);
		rdc("temp", REG_TEMP, 16'h4580);
		rdc("status", REG_CFG, 16'h0018);
		wr(REG_CFG, 16'h0028);
		evt(1'b0);
		set_temp(13'h0080);
		rdc("temp", REG_TEMP, 16'h2080);
		wr(REG_CFG, 16'h0108);
		evt(1'b0);
		wr(REG_CFG, 16'h000a);
		evt(1'b1);
		wr(REG_LOWER, 16'h0000);
		set_temp(13'h0080);
		evt(1'b0);
		wr(REG_LOWER, 16'h0100);
		set_temp(13'h0080);
		evt(1'b1);
		test_end("comparator");
		wr(REG_CFG, 16'h0000);
		wr(REG_CFG, 16'h0009);
		wr(REG_CFG, 16'h0029);
		evt(1'b1);
		set_temp(13'h0400);
		evt(1'b0);
		i_tae_host_model.bus_start();
		i_tae_host_model.xfer({ARA_ADDR, 1'b1, 1'b1}, q);
		chk_bit("alert ack", 1'b0, q[0]);
		i_tae_host_model.xfer(9'h1ff, q);
		i_tae_host_model.bus_stop();
		chk_reg("alert address", {8'h00, TS_ADDR_HI, 3'h5, 1'b0}, {8'h00, q[8:1]});
		evt(1'b1);
		wr(REG_CFG, 16'h0029);
		evt(1'b1);
		set_temp(13'h0580);
		evt(1'b0);
		wr(REG_CFG, 16'h0029);
		evt(1'b1);
		set_temp(13'h0700);
		evt(1'b0);
		wr(REG_CFG, 16'h0029);
		evt(1'b0);
		set_temp(13'h0580);
		evt(1'b1);
		test_end("interrupt");
		wr(REG_CFG, 16'h0000);
		wr(REG_CFG, 16'h020c);
		evt(1'b1);
		set_temp(13'h0700);
		evt(1'b0);
		wr(REG_CFG, 16'h022c);
		evt(1'b0);
		set_temp(13'h05e0);
		evt(1'b0);
		set_temp(13'h05d0);
		evt(1'b1);
		wr(REG_CFG, 16'h00c0);
		wr(REG_UPPER, 16'h0100);
		rdc("locked upper", REG_UPPER, 16'h0550);
		wr(REG_CFG, 16'h0000);
		test_end("critical band");
		rdc("capability", REG_CAP, CAP_VAL);
		i_tae_host_model.bus_start();
		i_tae_host_model.xfer({7'h1d, 1'b1, 1'b1}, q);
		i_tae_host_model.hold(20);
		chk_bit("sda driven", 1'b0, sda_o.oe_n);
		i_tae_host_model.hold(TOUT + 30);
		chk_bit("sda released", 1'b1, sda_o.oe_n);
		i_tae_host_model.bus_stop();
		rdc("after timeout", REG_CAP, CAP_VAL);
		wr(REG_SMB, 16'h0080);
		rdc("bus control", REG_SMB, 16'h0080);
		i_tae_host_model.bus_start();
		i_tae_host_model.xfer({7'h1d, 1'b1, 1'b1}, q);
		i_tae_host_model.hold(TOUT + 50);
		chk_bit("sda held", 1'b0, sda_o.oe_n);
		i_tae_host_model.xfer(9'h1ff, q);
		i_tae_host_model.bus_stop();
		chk_reg("late byte", 16'h0000, {8'h00, q[8:1]});
		test_end("timeout");
		results();
	end
endmodule

//--- rtl/tae_pkg.sv
// constants, register map and state types of the thermal alarm block
package tae_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int MS_PER_S = 1000;
	localparam int T_CONV_MS = 125;
	localparam int T_TOUT_MS = 25;
	localparam int CONV_CYC = CLK_HZ / MS_PER_S * T_CONV_MS;
	localparam int TOUT_CYC = CLK_HZ / MS_PER_S * T_TOUT_MS;
	localparam int CNT_W = 24;
	localparam int TEMP_W = 13;

	localparam logic [3:0] TS_ADDR_HI = 4'h3;
	localparam logic [6:0] ARA_ADDR = 7'h0c;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	localparam logic [7:0] REG_CAP = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h01;
	localparam logic [7:0] REG_UPPER = 8'h02;
	localparam logic [7:0] REG_LOWER = 8'h03;
	localparam logic [7:0] REG_CRIT = 8'h04;
	localparam logic [7:0] REG_TEMP = 8'h05;
	localparam logic [7:0] REG_SMB = 8'h22;

	localparam logic [15:0] CAP_VAL = 16'h0017;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [15:0] LIM_RST = 16'h0000;
	localparam logic [15:0] SMB_RST = 16'h0000;
	localparam logic [15:0] LIM_MASK = 16'h1ffc;
	localparam logic [15:0] CFG_WMASK = 16'h07cf;

	localparam int CFG_MODE = 0;
	localparam int CFG_POL = 1;
	localparam int CFG_CRIT = 2;
	localparam int CFG_OEN = 3;
	localparam int CFG_STAT = 4;
	localparam int CFG_CLR = 5;
	localparam int CFG_LKW = 6;
	localparam int CFG_LKC = 7;
	localparam int CFG_SHDN = 8;
	localparam int CFG_HYS = 9;
	localparam int SMB_TOUT_DIS = 7;

	// hysteresis in 1/16 degree steps: 0, 1.5, 3, 6 degrees
	localparam logic [3:0][TEMP_W:0] HYS_TAB = {14'h0060, 14'h0030, 14'h0018, 14'h0000};

	localparam logic [1:0] IDX_PTR = 2'h0;
	localparam logic [1:0] IDX_MSB = 2'h1;
	localparam logic [1:0] IDX_LSB = 2'h2;

	typedef enum logic [2:0] {
		BS_IDLE = 3'h0,
		BS_ADDR = 3'h1,
		BS_AACK = 3'h2,
		BS_WR = 3'h3,
		BS_WACK = 3'h4,
		BS_RD = 3'h5,
		BS_RACK = 3'h6
	} tae_bus_st_t;

	typedef struct packed {
		logic o;
		logic oe_n;
	} tae_od_t;

	typedef struct packed {
		logic valid;
		logic [TEMP_W-1:0] data;
	} tae_conv_t;

	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_q;
		logic sda_q;
		logic [2:0] adr_s1;
		logic [2:0] adr_s2;
		tae_bus_st_t bst;
		logic [3:0] bit_cnt;
		logic [7:0] sh;
		logic rw;
		logic ara;
		logic nack;
		logic rd_lsb;
		logic [1:0] byte_idx;
		logic [7:0] wr_msb;
		logic drv;
		logic [15:0] tx_word;
		logic [7:0] ptr;
		logic [15:0] cfg;
		logic [15:0] upper;
		logic [15:0] lower;
		logic [15:0] crit;
		logic [15:0] smb;
		logic [TEMP_W-1:0] temp;
		logic above_crit;
		logic above_win;
		logic below_win;
		logic ev_latch;
		logic stale;
		logic ev_drv;
		logic [CNT_W-1:0] conv_cnt;
		logic req_tgl;
		logic [1:0] done_s;
		logic done_q;
		logic [CNT_W-1:0] tout_cnt;
	} tae_main_t;

	typedef struct packed {
		logic [1:0] rst_s;
		logic [1:0] req_s;
		logic req_q;
		logic start;
		logic busy;
		logic done_tgl;
		logic [TEMP_W-1:0] data;
	} tae_cnv_t;
endpackage

//--- rtl/tae_thermal_alarm.sv
// thermal alarm, conversion scheduling and two-wire register slave
// Functional notes
// RULE_01: non-critical alarm clears by clear-alarm bit write or alert response.
// RULE_02: host keeps the upper limit above the lower limit.
// RULE_03: after a limit write, skip one full conversion before comparing again.
// RULE_04: host waits 125 ms after limits, enables output, waits 20 us, reads.
// RULE_05: with output enabled, critical reach asserts until temperature falls below it; code holds it until below critical minus hysteresis.
// RULE_06: above critical, clear-alarm bit and alert response cannot release the output.
// RULE_07: host keeps the critical limit above the upper limit.
// RULE_08: comparator asserts outside window; critical band asserts only above critical.
// RULE_09: comparator output unaffected by bus access; follows temperature and limits only.
// RULE_10: interrupt mode asserts on each window crossing; clear releases until next.
// RULE_11: interrupt mode critical rise re-asserts, releases as soon as it drops.
// RULE_12: conversions complete at least every 125 ms.
// RULE_13: temperature read returns newest completed result.
// RULE_14: a result landing mid-read does not alter that read's bytes.
// RULE_15: reset: monitoring, alarm clear, zero hysteresis, pointer 00h, zero limits.
// RULE_16: reset: output disabled, comparator, active low, unlocked, time-out on.
// RULE_17: serial clock low 25 ms returns the bus engine to idle.
// RULE_18: bit 7 of register 22h set disables the bus time-out.
// RULE_19: host keeps the serial clock at 10 kHz or faster with time-out on.
// RULE_20: serial clock is never driven, so never stretched.
// RULE_21: shutdown stops the timebase, so time-out stops too.
// RULE_22: config bit 0 mode, bit 2 critical band, bits 10:9 hysteresis.
// RULE_23: config bit 1 polarity, bit 3 enable, bit 4 status, bit 5 clear.
// RULE_24: alarm asserted on entering shutdown stays asserted through shutdown.
// RULE_25: alarm evaluated per new result; hysteresis only on return paths.
`timescale 1ns/10ps
module tae_thermal_alarm
	import tae_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYC,
	parameter int TOUT_CYCLES = TOUT_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic conv_clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [2:0] addr_sel_i,
	input wire tae_conv_t conv_i,
	output logic conv_start_o,
	output tae_od_t sda_o,
	output tae_od_t event_o
);

	if (CONV_CYCLES < 2 || CONV_CYCLES >= (1 << CNT_W)) begin : g_bad_conv
		$error("conversion period out of range");
	end
	if (TOUT_CYCLES < 2 || TOUT_CYCLES >= (1 << CNT_W)) begin : g_bad_tout
		$error("time-out period out of range");
	end

	// RULE_15 power-on defaults
	// RULE_16 output off, comparator, active low, unlocked, time-out on
	localparam tae_main_t MAIN_RST = '{bst: BS_IDLE, ptr: REG_CAP, cfg: CFG_RST,
		upper: LIM_RST, lower: LIM_RST, crit: LIM_RST, smb: SMB_RST, default: '0};

	tae_main_t s;
	tae_main_t n;
	tae_cnv_t c;
	tae_cnv_t cn;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic new_res;
	logic tout_en;
	logic tout_hit;
	logic wr_commit;
	logic clr_req;
	logic ara_clr;
	logic ara_pend;
	logic alarm;
	logic ev_set;
	logic [15:0] wr_word;
	logic [15:0] rd_word;
	logic [15:0] temp_word;
	logic [15:0] ara_word;
	logic [TEMP_W:0] hys;

	assign scl = s.scl_s[1];
	assign sda = s.sda_s[1];
	assign scl_rise = scl & ~s.scl_q;
	assign scl_fall = ~scl & s.scl_q;
	assign bus_start = scl & s.scl_q & s.sda_q & ~sda;
	assign bus_stop = scl & s.scl_q & ~s.sda_q & sda;
	assign new_res = s.done_s[1] ^ s.done_q;
	assign wr_word = {s.wr_msb, s.sh};
	assign wr_commit = scl_fall && s.bst == BS_WR && s.bit_cnt == BYTE_BITS
		&& s.byte_idx == IDX_LSB;
	// RULE_23 clear-alarm bit write
	assign clr_req = wr_commit && s.ptr == REG_CFG && wr_word[CFG_CLR];
	// RULE_01 alert response completes
	assign ara_clr = scl_rise && s.bst == BS_RACK && s.ara;
	assign ara_pend = s.cfg[CFG_MODE] & ~s.cfg[CFG_POL] & s.ev_latch;
	// RULE_18 time-out disable bit
	// RULE_21 shutdown stops the time-out
	assign tout_en = !s.smb[SMB_TOUT_DIS] && !s.cfg[CFG_SHDN];
	assign tout_hit = tout_en && !scl && s.tout_cnt == CNT_W'(TOUT_CYCLES - 1);
	// RULE_22 hysteresis select
	assign hys = HYS_TAB[s.cfg[CFG_HYS +: 2]];
	assign temp_word = {s.above_crit, s.above_win, s.below_win, s.temp};
	assign ara_word = {TS_ADDR_HI, s.adr_s2, 1'b0, 8'h00};

	// RULE_08 comparator window or critical band only
	// RULE_11 critical term in interrupt mode follows temperature directly
	// RULE_09 comparator term reads flags only
	assign alarm = s.cfg[CFG_CRIT] ? s.above_crit
		: s.cfg[CFG_MODE] ? (s.ev_latch | s.above_crit)
		: (s.above_crit | s.above_win | s.below_win);

	// RULE_23 status bit shows the alarm, clear bit reads zero
	always_comb begin
		case (s.ptr)
			REG_CAP: rd_word = CAP_VAL;
			REG_CFG: rd_word = s.cfg | (16'(alarm) << CFG_STAT);
			REG_UPPER: rd_word = s.upper;
			REG_LOWER: rd_word = s.lower;
			REG_CRIT: rd_word = s.crit;
			REG_TEMP: rd_word = temp_word;
			REG_SMB: rd_word = s.smb;
			default: rd_word = '0;
		endcase
	end

	always_comb begin
		logic signed [TEMP_W:0] t;
		logic signed [TEMP_W:0] up;
		logic signed [TEMP_W:0] lo;
		logic signed [TEMP_W:0] cr;
		logic signed [TEMP_W:0] hy;
		logic crit_n;
		logic aw_n;
		logic bw_n;
		logic [15:0] word;
		t = $signed({c.data[TEMP_W-1], c.data});
		up = $signed({s.upper[TEMP_W-1], s.upper[TEMP_W-1:0]});
		lo = $signed({s.lower[TEMP_W-1], s.lower[TEMP_W-1:0]});
		cr = $signed({s.crit[TEMP_W-1], s.crit[TEMP_W-1:0]});
		hy = $signed(hys);
		// RULE_25 evaluate on each new result, hysteresis on return
		crit_n = s.above_crit ? (t >= cr - hy) : (t >= cr);
		aw_n = s.above_win ? (t > up - hy) : (t > up);
		bw_n = s.below_win ? (t < lo + hy) : (t < lo);
		word = '0;
		ev_set = 1'b0;
		n = s;
		n.scl_s = {s.scl_s[0], scl_i};
		n.sda_s = {s.sda_s[0], sda_i};
		n.scl_q = scl;
		n.sda_q = sda;
		n.adr_s1 = addr_sel_i;
		n.adr_s2 = s.adr_s1;
		n.done_s = {s.done_s[0], c.done_tgl};
		n.done_q = s.done_s[1];

		// RULE_12 conversion timebase
		// RULE_21 halted in shutdown
		if (!s.cfg[CFG_SHDN]) begin
			if (s.conv_cnt == CNT_W'(CONV_CYCLES - 1)) begin
				n.conv_cnt = '0;
				n.req_tgl = ~s.req_tgl;
			end else begin
				n.conv_cnt = s.conv_cnt + 1'b1;
			end
		end

		if (new_res) begin
			// RULE_13 newest result feeds the temperature register
			n.temp = c.data;
			// RULE_03 first result after a limit write is not compared
			if (s.stale) begin
				n.stale = 1'b0;
			end else if (!s.cfg[CFG_SHDN]) begin
				// RULE_05 critical hold until below threshold minus hysteresis
				n.above_crit = crit_n;
				n.above_win = aw_n;
				n.below_win = bw_n;
				// RULE_10 each crossing latches in interrupt mode
				if (s.cfg[CFG_MODE] && (aw_n != s.above_win || bw_n != s.below_win)) begin
					n.ev_latch = 1'b1;
					ev_set = 1'b1;
				end
			end
		end

		// RULE_17 clock held low resets the bus engine
		n.tout_cnt = (tout_en && !scl) ? s.tout_cnt + 1'b1 : '0;
		if (tout_hit || bus_stop) begin
			n.bst = BS_IDLE;
			n.drv = 1'b0;
			n.tout_cnt = '0;
		end else if (bus_start) begin
			n.bst = BS_ADDR;
			n.bit_cnt = '0;
			n.drv = 1'b0;
		end else begin
			unique case (s.bst)
				BS_IDLE: begin
				end
				BS_ADDR: begin
					if (scl_rise) begin
						n.sh = {s.sh[6:0], sda};
						n.bit_cnt = s.bit_cnt + 1'b1;
					end else if (scl_fall && s.bit_cnt == BYTE_BITS) begin
						if (s.sh[7:1] == {TS_ADDR_HI, s.adr_s2}) begin
							n.drv = 1'b1;
							n.rw = s.sh[0];
							n.ara = 1'b0;
							n.bst = BS_AACK;
						end else if (s.sh == {ARA_ADDR, 1'b1} && ara_pend) begin
							n.drv = 1'b1;
							n.rw = 1'b1;
							n.ara = 1'b1;
							n.bst = BS_AACK;
						end else begin
							n.bst = BS_IDLE;
						end
					end
				end
				BS_AACK: begin
					if (scl_fall) begin
						n.bit_cnt = '0;
						if (s.rw) begin
							// RULE_14 whole word captured once per read
							word = s.ara ? ara_word : rd_word;
							n.tx_word = word;
							n.sh = word[15:8];
							n.drv = ~word[15];
							n.rd_lsb = 1'b1;
							n.bst = BS_RD;
						end else begin
							n.drv = 1'b0;
							n.byte_idx = IDX_PTR;
							n.bst = BS_WR;
						end
					end
				end
				BS_WR: begin
					if (scl_rise) begin
						n.sh = {s.sh[6:0], sda};
						n.bit_cnt = s.bit_cnt + 1'b1;
					end else if (scl_fall && s.bit_cnt == BYTE_BITS) begin
						n.drv = 1'b1;
						n.bst = BS_WACK;
						if (s.byte_idx == IDX_PTR) begin
							n.ptr = s.sh;
							n.byte_idx = IDX_MSB;
						end else if (s.byte_idx == IDX_MSB) begin
							n.wr_msb = s.sh;
							n.byte_idx = IDX_LSB;
						end else begin
							n.byte_idx = IDX_MSB;
							case (s.ptr)
								REG_CFG: begin
									// RULE_22 mode and band bits
									n.cfg = wr_word & CFG_WMASK;
									// mode and band freeze while output stays enabled
									if (s.cfg[CFG_OEN] && wr_word[CFG_OEN]) begin
										n.cfg[CFG_MODE] = s.cfg[CFG_MODE];
										n.cfg[CFG_CRIT] = s.cfg[CFG_CRIT];
									end
								end
								REG_UPPER: begin
									if (!s.cfg[CFG_LKW]) begin
										n.upper = wr_word & LIM_MASK;
										n.stale = 1'b1;
									end
								end
								REG_LOWER: begin
									if (!s.cfg[CFG_LKW]) begin
										n.lower = wr_word & LIM_MASK;
										n.stale = 1'b1;
									end
								end
								REG_CRIT: begin
									if (!s.cfg[CFG_LKC]) begin
										n.crit = wr_word & LIM_MASK;
										n.stale = 1'b1;
									end
								end
								REG_SMB: n.smb = wr_word;
								default: begin
								end
							endcase
						end
					end
				end
				BS_WACK: begin
					if (scl_fall) begin
						n.drv = 1'b0;
						n.bit_cnt = '0;
						n.bst = BS_WR;
					end
				end
				BS_RD: begin
					if (scl_rise) begin
						n.bit_cnt = s.bit_cnt + 1'b1;
					end else if (scl_fall) begin
						if (s.bit_cnt == BYTE_BITS) begin
							n.drv = 1'b0;
							n.bst = BS_RACK;
						end else begin
							n.drv = ~s.sh[6];
							n.sh = {s.sh[6:0], 1'b0};
						end
					end
				end
				BS_RACK: begin
					if (scl_rise) begin
						n.nack = sda;
					end else if (scl_fall) begin
						if (s.nack || s.ara) begin
							n.bst = BS_IDLE;
						end else begin
							word = s.tx_word;
							n.sh = s.rd_lsb ? word[7:0] : word[15:8];
							n.drv = s.rd_lsb ? ~word[7] : ~word[15];
							n.rd_lsb = ~s.rd_lsb;
							n.bit_cnt = '0;
							n.bst = BS_RD;
						end
					end
				end
				default: n.bst = BS_IDLE;
			endcase
		end

		// RULE_01 clear by bit or alert response, a new crossing wins
		// RULE_06 critical term is outside the latch, so it stays
		if ((clr_req || ara_clr) && !ev_set) begin
			n.ev_latch = 1'b0;
		end

		// RULE_23 enable and polarity onto the open-drain pin
		// RULE_24 flags freeze in shutdown, so the pin holds
		n.ev_drv = s.cfg[CFG_OEN] & (alarm ^ s.cfg[CFG_POL]);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s <= MAIN_RST;
		end else begin
			s <= n;
		end
	end

	// converter side: request toggle in, result word held with done toggle out
	always_comb begin
		cn = c;
		cn.rst_s = {c.rst_s[0], rst_n_i};
		cn.req_s = {c.req_s[0], s.req_tgl};
		cn.req_q = c.req_s[1];
		cn.start = c.req_s[1] ^ c.req_q;
		if (c.start) begin
			cn.busy = 1'b1;
		end
		if (c.busy && conv_i.valid) begin
			cn.data = conv_i.data;
			cn.done_tgl = ~c.done_tgl;
			cn.busy = 1'b0;
		end
		if (!c.rst_s[1]) begin
			cn.start = 1'b0;
			cn.busy = 1'b0;
			cn.done_tgl = 1'b0;
			cn.data = '0;
		end
	end

	always_ff @(posedge conv_clk_i) begin
		c <= cn;
	end

	// RULE_20 serial clock is input only; data and alarm are open drain
	assign sda_o = '{o: 1'b0, oe_n: ~s.drv};
	assign event_o = '{o: 1'b0, oe_n: ~s.ev_drv};
	assign conv_start_o = c.start;

	logic conv_in_range;
	assign conv_in_range = s.conv_cnt < CNT_W'(CONV_CYCLES);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_CLR_RELEASE: assert property (clr_req && !ev_set |=> !s.ev_latch) // RULE_01
		else $error("clear-alarm write did not release latch");
	AST_LIMIT_WAIT: assert property (s.stale && new_res |=> $stable(s.above_win) // RULE_03
		&& $stable(s.below_win) && $stable(s.above_crit))
		else $error("result compared right after limit write");
	AST_CRIT_DRIVE: assert property (s.above_crit && s.cfg[CFG_OEN] && !s.cfg[CFG_POL] // RULE_05
		|=> s.ev_drv)
		else $error("critical alarm not driven");
	AST_CRIT_NOCLR: assert property (s.above_crit && (clr_req || ara_clr) |=> alarm) // RULE_06
		else $error("critical alarm released by clear");
	AST_CMP_WIN: assert property (!s.cfg[CFG_MODE] && !s.cfg[CFG_CRIT] // RULE_08
		&& (s.above_win || s.below_win)
		|-> alarm ##1 (s.ev_drv == $past(s.cfg[CFG_OEN] & ~s.cfg[CFG_POL])))
		else $error("comparator outside window not asserted");
	AST_CMP_STABLE: assert property (!s.cfg[CFG_MODE] && !new_res && !wr_commit // RULE_09
		|=> $stable(alarm))
		else $error("comparator alarm moved without cause");
	AST_INT_SET: assert property ($rose(s.ev_latch) |-> $past(new_res)) // RULE_10
		else $error("interrupt latch set without a result");
	AST_CRIT_DROP: assert property (s.cfg[CFG_MODE] && !s.cfg[CFG_CRIT] // RULE_11
		&& $fell(s.above_crit) && !s.ev_latch
		|-> !alarm ##1 (s.ev_drv == $past(s.cfg[CFG_OEN] & s.cfg[CFG_POL])))
		else $error("critical drop did not release");
	AST_CONV_RATE: assert property (conv_in_range) // RULE_12
		else $error("conversion timer overran");
	AST_READ_FROZEN: assert property (s.bst == BS_RD |=> s.bst != BS_RD // RULE_14
		|| $stable(s.tx_word))
		else $error("read word changed during shift");
	AST_TIMEOUT: assert property (tout_hit |=> s.bst == BS_IDLE && !s.drv) // RULE_17
		else $error("time-out did not idle the bus");
	AST_SHDN_HOLD: assert property (s.cfg[CFG_SHDN] && s.ev_drv && !wr_commit // RULE_24
		|=> s.ev_drv)
		else $error("alarm dropped during shutdown");

	COV_RESULT_ALARM: cover property (new_res ##1 alarm);
	COV_ARA: cover property (ara_clr);
	COV_TIMEOUT: cover property (tout_hit);
endmodule
